// [logic/ddr2_init_pkg.sv]
// Shared constants for the DDR2 mode-register and command decode block.
// Assumes a 14-bit address bus (x4/x8 part), four banks, APB register port.
package ddr2_init_pkg;
	localparam int ADDR_W = 14;
	localparam int COL_W = 10;
	// Main mode register fields
	localparam int MR_BL_LSB = 0;
	localparam int MR_BT_BIT = 3;
	localparam int MR_CL_LSB = 4;
	localparam int MR_TM_BIT = 7;
	localparam int MR_DLL_RST_BIT = 8;
	localparam int MR_WR_LSB = 9;
	localparam logic [2:0] BL_EIGHT = 3'h3;
	// First extended register fields
	localparam int E1_DLL_DIS_BIT = 0;
	localparam int E1_HALF_DRV_BIT = 1;
	localparam int E1_ODT_LO_BIT = 2;
	localparam int E1_AL_LSB = 3;
	localparam int E1_ODT_HI_BIT = 6;
	localparam int E1_CAL_LSB = 7;
	localparam int E1_DQSN_DIS_BIT = 10;
	localparam int E1_READ_ONLY_STROBE_EN_BIT = 11;
	localparam int E1_QOFF_BIT = 12;
	// Address bit that means auto-precharge or precharge-all
	localparam int AP_BIT = 10;
	// Link clocks from the DLL reset to a safe read
	localparam logic [7:0] DLL_LOCK_CYCLES = 8'hC8;
	// Command code is {ras_n, cas_n, we_n} with cs_n low
	typedef enum logic [2:0] {
		CMD_MODE = 3'b000,
		CMD_REFRESH = 3'b001,
		CMD_PRECHARGE = 3'b010,
		CMD_ACTIVATE = 3'b011,
		CMD_WRITE = 3'b100,
		CMD_READ = 3'b101,
		CMD_TERMINATE = 3'b110,
		CMD_NOP = 3'b111
	} cmd_t;
	typedef enum logic [1:0] {
		DLL_OFF = 2'b00,
		DLL_LOCKING = 2'b01,
		DLL_LOCKED = 2'b10
	} dll_state_t;
	// APB byte offsets
	localparam logic [11:0] OFS_CONTROL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_MR = 12'h008;
	localparam logic [11:0] OFS_EMR1 = 12'h00C;
	localparam logic [11:0] OFS_EMR2 = 12'h010;
	localparam logic [11:0] OFS_EMR3 = 12'h014;
	localparam logic [11:0] OFS_ERRORS = 12'h018;
	localparam int CTRL_DECODE_BIT = 0;
	localparam int CTRL_CLR_ERR_BIT = 1;
	localparam logic CONTROL_RESET = 1'b1;
	localparam int ST_WRITTEN_LSB = 0;
	localparam int ST_DLL_LSB = 4;
	localparam int ST_OPEN_LSB = 8;
	localparam int ST_READ_ONLY_STROBE_BIT = 12;
endpackage

// [logic/row_store.sv]
// Open-row memory: one row address per bank, registered read data.
// Assumes writes and reads come from logic on the same clock.
`timescale 1ns/1ns
module row_store (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [1:0] wr_bank,
	input wire logic [ddr2_init_pkg::ADDR_W-1:0] wr_row,
	input wire logic [1:0] rd_bank,
	output logic [ddr2_init_pkg::ADDR_W-1:0] rd_row
);
	logic [ddr2_init_pkg::ADDR_W-1:0] rows [0:3];

	// Array holds no reset; only the output register does
	always_ff @(posedge clk) begin
		if (wr_en) begin
			rows[wr_bank] <= wr_row;
		end
	end

	// Read data always comes from a register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_row <= '0;
		end else begin
			rd_row <= rows[rd_bank];
		end
	end
endmodule // row_store

// [logic/ddr2_mode_device.sv]
// Device-side command decoder: mode registers, bank state, access capture.
// Assumes link pins are asynchronous to clk and ck is slower than clk / 4.
`timescale 1ns/1ns
// How it works
// - Activate opens the bank given by two bank bits with a 14-bit row.
// - Read/write address gives start column; A10 requests auto-precharge.
// - Both bank bits decode which mode register a mode set writes.
// - Mode writes and DLL reset leave stored rows and data untouched.
// - All-low command with bank bits zero writes main mode register.
// - Main register: burst length A0-A2, type A3, read latency A4-A6.
// - A7 test mode, A8 DLL reset, A9-A11 write recovery.
// - First extended: DLL, drive, latency, calibration, strobe fields.
// - Termination setting comes from A2 and A6 of first extended.
// - Read strobe enabled disables write mask, strobe used on reads only.
module ddr2_mode_device (
	input wire logic clk,
	input wire logic rst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ck,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic bank_select_low,
	input wire logic bank_select_high,
	input wire logic bank_select_reserved,
	input wire logic [13:0] addr,
	input wire logic die_termination_control,
	output logic termination_on,
	output logic write_byte_mask_on,
	output logic dll_ready,
	output logic [13:0] mode_reg,
	output logic [13:0] first_extended_register,
	output logic [13:0] second_extended_register,
	output logic [13:0] third_extended_register,
	output logic access_valid,
	output logic access_write,
	output logic [1:0] access_bank,
	output logic [13:0] access_row,
	output logic [9:0] access_column,
	output logic access_auto_precharge,
	output logic command_error
);
	localparam int PIN_W = 24;
	localparam int COL_W_END = ddr2_init_pkg::COL_W - 1;

	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic ck_s3;
	logic ck_rise;
	logic s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n;
	logic s_bank_select_reserved, s_odt;
	logic [1:0] s_bank;
	logic [13:0] s_addr;
	ddr2_init_pkg::cmd_t cmd;
	logic cmd_take;

	logic control_decode;
	logic next_control_decode;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic clear_errors;
	logic [31:0] status_word;

	logic [3:0] bank_open, next_bank_open;
	logic [3:0] mode_written, next_mode_written;
	logic [13:0] next_mode_reg, next_first_ext;
	logic [13:0] next_second_ext, next_third_ext;
	logic [15:0] error_count, next_error_count;
	logic next_error;
	logic next_access_write, next_access_ap;
	logic [1:0] next_access_bank;
	logic [9:0] next_access_column;
	logic access_pending, next_access_pending;
	logic row_wr_en;
	logic dll_restart, dll_stop;
	logic [13:0] stored_row;

	ddr2_init_pkg::dll_state_t dll_state, next_dll_state;
	logic [7:0] dll_count, next_dll_count;
	logic next_dll_ready, next_termination_on, next_mask_on;

	// Every link pin crosses through two flops; stage two is decoded, and ck also from a third flop for the edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			ck_s3 <= 1'b0;
		end else begin
			pin_s1 <= {ck, cke, cs_n, ras_n, cas_n, we_n,
				bank_select_reserved, bank_select_high,
				bank_select_low, addr, die_termination_control};
			pin_s2 <= pin_s1;
			ck_s3 <= pin_s2[23];
		end
	end

	// Unpack synchronised pins; ck rising edge marks a command slot
	assign ck_rise = pin_s2[23] & ~ck_s3;
	assign s_cke = pin_s2[22];
	assign s_cs_n = pin_s2[21];
	assign s_ras_n = pin_s2[20];
	assign s_cas_n = pin_s2[19];
	assign s_we_n = pin_s2[18];
	assign s_bank_select_reserved = pin_s2[17];
	assign s_bank = pin_s2[16:15];
	assign s_addr = pin_s2[14:1];
	assign s_odt = pin_s2[0];
	assign cmd = ddr2_init_pkg::cmd_t'({s_ras_n, s_cas_n, s_we_n});
	// Commands count only with clock enable high and the decoder on
	assign cmd_take = ck_rise & s_cke & ~s_cs_n & control_decode;

	// Status view of the block's own state
	always_comb begin
		status_word = '0;
		status_word[ddr2_init_pkg::ST_WRITTEN_LSB +: 4] = mode_written;
		status_word[ddr2_init_pkg::ST_DLL_LSB +: 2] = dll_state;
		status_word[ddr2_init_pkg::ST_OPEN_LSB +: 4] = bank_open;
		status_word[ddr2_init_pkg::ST_READ_ONLY_STROBE_BIT] =
			first_extended_register[ddr2_init_pkg::E1_READ_ONLY_STROBE_EN_BIT];
	end

	// APB slave: no wait states, ready and data both registered
	always_comb begin
		next_pready = psel & ~penable;
		next_pslverr = 1'b0;
		next_prdata = '0;
		next_control_decode = control_decode;
		clear_errors = 1'b0;
		case (paddr)
			ddr2_init_pkg::OFS_CONTROL: begin
				next_prdata[ddr2_init_pkg::CTRL_DECODE_BIT] = control_decode;
			end
			ddr2_init_pkg::OFS_STATUS: next_prdata = status_word;
			ddr2_init_pkg::OFS_MR: next_prdata = {18'h0, mode_reg};
			ddr2_init_pkg::OFS_EMR1: begin
				next_prdata = {18'h0, first_extended_register};
			end
			ddr2_init_pkg::OFS_EMR2: begin
				next_prdata = {18'h0, second_extended_register};
			end
			ddr2_init_pkg::OFS_EMR3: begin
				next_prdata = {18'h0, third_extended_register};
			end
			ddr2_init_pkg::OFS_ERRORS: next_prdata = {16'h0, error_count};
			default: next_pslverr = psel & ~penable;
		endcase
		if (!next_pready) begin
			next_prdata = '0;
		end
		// A write lands only at the access edge that sees pready
		if (psel && penable && pready && pwrite && !pslverr &&
			paddr == ddr2_init_pkg::OFS_CONTROL) begin
			next_control_decode = pwdata[ddr2_init_pkg::CTRL_DECODE_BIT];
			clear_errors = pwdata[ddr2_init_pkg::CTRL_CLR_ERR_BIT];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			control_decode <= ddr2_init_pkg::CONTROL_RESET;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			control_decode <= next_control_decode;
		end
	end

	// Command decode; a protocol slip is flagged and the command dropped
	always_comb begin
		next_bank_open = bank_open;
		next_mode_written = mode_written;
		next_mode_reg = mode_reg;
		next_first_ext = first_extended_register;
		next_second_ext = second_extended_register;
		next_third_ext = third_extended_register;
		next_error = 1'b0;
		next_access_pending = 1'b0;
		next_access_write = access_write;
		next_access_bank = access_bank;
		next_access_column = access_column;
		next_access_ap = access_auto_precharge;
		row_wr_en = 1'b0;
		dll_restart = 1'b0;
		dll_stop = 1'b0;
		if (cmd_take) begin
			case (cmd)
				ddr2_init_pkg::CMD_MODE: begin
					// Open banks make a mode set illegal; rows are kept
					if (bank_open != 4'h0 || s_bank_select_reserved) begin
						next_error = 1'b1;
					end else begin
						next_mode_written[s_bank] = 1'b1;
						case (s_bank)
							2'h0: begin
								next_mode_reg = s_addr;
								dll_restart =
									s_addr[ddr2_init_pkg::MR_DLL_RST_BIT];
							end
							2'h1: begin
								next_first_ext = s_addr;
								dll_stop =
									s_addr[ddr2_init_pkg::E1_DLL_DIS_BIT];
							end
							2'h2: next_second_ext = s_addr;
							default: next_third_ext = s_addr;
						endcase
					end
				end
				ddr2_init_pkg::CMD_ACTIVATE: begin
					// Bank bits pick the bank; full address is the row
					if (bank_open[s_bank]) begin
						next_error = 1'b1;
					end else begin
						next_bank_open[s_bank] = 1'b1;
						row_wr_en = 1'b1;
					end
				end
				ddr2_init_pkg::CMD_READ, ddr2_init_pkg::CMD_WRITE: begin
					// Closed bank, or a read before lock, is refused
					if (!bank_open[s_bank] ||
						(cmd == ddr2_init_pkg::CMD_READ &&
						dll_state != ddr2_init_pkg::DLL_LOCKED)) begin
						next_error = 1'b1;
					end else begin
						next_access_pending = 1'b1;
						next_access_write = (cmd == ddr2_init_pkg::CMD_WRITE);
						next_access_bank = s_bank;
						next_access_column = s_addr[COL_W_END:0];
						next_access_ap = s_addr[ddr2_init_pkg::AP_BIT];
						// Bank closes now; burst timing is outside this block
						if (s_addr[ddr2_init_pkg::AP_BIT]) begin
							next_bank_open[s_bank] = 1'b0;
						end
					end
				end
				ddr2_init_pkg::CMD_PRECHARGE: begin
					if (s_addr[ddr2_init_pkg::AP_BIT]) begin
						next_bank_open = 4'h0;
					end else begin
						next_bank_open[s_bank] = 1'b0;
					end
				end
				ddr2_init_pkg::CMD_REFRESH: begin
					next_error = (bank_open != 4'h0);
				end
				default: ;
			endcase
		end
		// A new error wins over a clear in the same cycle
		next_error_count = clear_errors ? 16'h0 : error_count;
		if (next_error && next_error_count != 16'hFFFF) begin
			next_error_count = next_error_count + 16'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bank_open <= 4'h0;
			mode_written <= 4'h0;
			mode_reg <= '0;
			first_extended_register <= '0;
			second_extended_register <= '0;
			third_extended_register <= '0;
			error_count <= 16'h0;
			command_error <= 1'b0;
			access_pending <= 1'b0;
			access_valid <= 1'b0;
			access_write <= 1'b0;
			access_bank <= 2'h0;
			access_column <= '0;
			access_auto_precharge <= 1'b0;
			access_row <= '0;
		end else begin
			bank_open <= next_bank_open;
			mode_written <= next_mode_written;
			mode_reg <= next_mode_reg;
			first_extended_register <= next_first_ext;
			second_extended_register <= next_second_ext;
			third_extended_register <= next_third_ext;
			error_count <= next_error_count;
			command_error <= next_error;
			access_pending <= next_access_pending;
			access_valid <= access_pending;
			access_write <= next_access_write;
			access_bank <= next_access_bank;
			access_column <= next_access_column;
			access_auto_precharge <= next_access_ap;
			access_row <= stored_row;
		end
	end

	// Row per bank; read port follows the bank of the current command
	row_store u_rows (
		.clk(clk),
		.rst(rst),
		.wr_en(row_wr_en),
		.wr_bank(s_bank),
		.wr_row(s_addr),
		.rd_bank(s_bank),
		.rd_row(stored_row)
	);

	// DLL lock timer counts link clock edges after each DLL reset
	always_comb begin
		next_dll_state = dll_state;
		next_dll_count = dll_count;
		case (dll_state)
			ddr2_init_pkg::DLL_OFF: ;
			ddr2_init_pkg::DLL_LOCKING: begin
				if (ck_rise) begin
					next_dll_count = dll_count + 8'h1;
					if (next_dll_count == ddr2_init_pkg::DLL_LOCK_CYCLES) begin
						next_dll_state = ddr2_init_pkg::DLL_LOCKED;
					end
				end
			end
			ddr2_init_pkg::DLL_LOCKED: ;
			default: next_dll_state = ddr2_init_pkg::DLL_OFF;
		endcase
		// Disable beats a restart; DLL reset needs DLL enabled
		if (dll_stop) begin
			next_dll_state = ddr2_init_pkg::DLL_OFF;
		end else if (dll_restart &&
			!first_extended_register[ddr2_init_pkg::E1_DLL_DIS_BIT]) begin
			next_dll_state = ddr2_init_pkg::DLL_LOCKING;
			next_dll_count = 8'h0;
		end
		next_dll_ready = (next_dll_state == ddr2_init_pkg::DLL_LOCKED);
		// Termination applies only when a setting is programmed
		next_termination_on = s_odt &
			(first_extended_register[ddr2_init_pkg::E1_ODT_HI_BIT] |
			first_extended_register[ddr2_init_pkg::E1_ODT_LO_BIT]);
		// Read strobe takes the mask pin over
		next_mask_on =
			~first_extended_register[ddr2_init_pkg::E1_READ_ONLY_STROBE_EN_BIT];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dll_state <= ddr2_init_pkg::DLL_OFF;
			dll_count <= 8'h0;
			dll_ready <= 1'b0;
			termination_on <= 1'b0;
			write_byte_mask_on <= 1'b1;
		end else begin
			dll_state <= next_dll_state;
			dll_count <= next_dll_count;
			dll_ready <= next_dll_ready;
			termination_on <= next_termination_on;
			write_byte_mask_on <= next_mask_on;
		end
	end
endmodule // ddr2_mode_device

// [sim/ddr2_mode_device_props.sv]
// Checker for the mode-register device: APB timing, link decode, DLL.
// Assumes it is bound to ddr2_mode_device and sees only its ports.
`timescale 1ns/1ns
module ddr2_mode_device_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic die_termination_control,
	input wire logic termination_on,
	input wire logic write_byte_mask_on,
	input wire logic dll_ready,
	input wire logic [13:0] mode_reg,
	input wire logic [13:0] first_extended_register,
	input wire logic [13:0] second_extended_register,
	input wire logic [13:0] third_extended_register,
	input wire logic access_valid,
	input wire logic command_error
);
	logic [10:0] lock_cnt;
	logic [10:0] next_lock_cnt;
	logic prev_rst;
	logic next_prev_rst;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Cycles since the DLL reset bit rose; saturates well past the lock time
	always_comb begin
		next_prev_rst = mode_reg[8];
		next_lock_cnt = lock_cnt + {10'h000, ~&lock_cnt};
		if (mode_reg[8] && !prev_rst)
			next_lock_cnt = 11'h000;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lock_cnt <= 11'h000;
			prev_rst <= 1'b0;
		end else begin
			lock_cnt <= next_lock_cnt;
			prev_rst <= next_prev_rst;
		end
	end
	// APB: setup cycle, then exactly one access cycle with pready
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_one_ready;
		pready ##1 !pready;
	endsequence
	a_ready_once: assert property (s_setup |=> s_one_ready)
		else $error("pready not one cycle after setup");
	a_error_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_unmapped_refused: assert property (
		s_setup ##0 (paddr > ddr2_init_pkg::OFS_ERRORS)
		|=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_access_pulse: assert property (access_valid |=> !access_valid)
		else $error("access_valid longer than one cycle");
	a_refusal_pulse: assert property (command_error |=> !command_error)
		else $error("command_error longer than one cycle");
	a_mask_tracks: assert property (
		$changed(first_extended_register[11]) |-> ##[0:2]
		(write_byte_mask_on != first_extended_register[11]))
		else $error("write mask does not follow strobe enable");
	a_term_gated: assert property (
		(!die_termination_control || !(first_extended_register[2] ||
		first_extended_register[6]))[*8] |-> !termination_on)
		else $error("termination on without pin and setting");
	a_dll_disabled: assert property (
		first_extended_register[0][*3] |-> !dll_ready)
		else $error("dll_ready while DLL disabled");
	a_regs_idle: assert property ((!cke || cs_n)[*4] |=>
		$stable({mode_reg, first_extended_register,
		second_extended_register, third_extended_register}))
		else $error("mode register changed without a command");
	a_lock_wait: assert property (
		$rose(dll_ready) |-> lock_cnt >= 11'h5DC)
		else $error("DLL ready too soon after reset bit");
endmodule // ddr2_mode_device_props

bind ddr2_mode_device ddr2_mode_device_props u_props (
	.clk, .rst, .paddr, .psel, .penable, .prdata, .pready, .pslverr,
	.cke, .cs_n, .die_termination_control, .termination_on,
	.write_byte_mask_on, .dll_ready, .mode_reg, .first_extended_register,
	.second_extended_register, .third_extended_register, .access_valid,
	.command_error
);

// [sim/ddr2_ctrl_model.sv]
// Controller-side model: free-running link clock and command pins.
// Assumes the device samples the pins around the ck rising edge.
`timescale 1ns/1ns
module ddr2_ctrl_model (
	output logic ck,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic bank_select_low,
	output logic bank_select_high,
	output logic bank_select_reserved,
	output logic [13:0] addr,
	output logic die_termination_control,
	output logic init_done
);
	localparam logic [13:0] MR_OPS = 14'h0453;
	localparam logic [13:0] E1_OPS = 14'h000C;
	// Clock enable and termination low while power comes up
	initial begin
		cke = 1'b0;
		die_termination_control = 1'b0;
		init_done = 1'b0;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		{bank_select_reserved, bank_select_high, bank_select_low} = 3'h0;
		addr = 14'h0000;
		ck = 1'b0;
		#7; // Phase offset keeps ck unrelated to the system clock
		forever #160 ck = ~ck;
	end
	// One command per call with a deselect period after it
	task automatic cmd(input logic [2:0] c, input logic [2:0] ba,
		input logic [13:0] a);
		@(negedge ck);
		{ras_n, cas_n, we_n} = c;
		{bank_select_reserved, bank_select_high, bank_select_low} = ba;
		addr = a;
		cs_n = 1'b0;
		@(negedge ck);
		cs_n = 1'b1;
		// Released lines do not keep their old value
		{ras_n, cas_n, we_n} = ~c;
		{bank_select_reserved, bank_select_high, bank_select_low} = ~ba;
		addr = ~a;
	endtask
	// Power-up order; all four mode registers get written
	task automatic init_seq();
		#200000;
		@(negedge ck);
		cke = 1'b1;
		#400;
		cmd(3'h2, 3'h0, 14'h0400);
		cmd(3'h0, 3'h2, 14'h0000);
		cmd(3'h0, 3'h3, 14'h0000);
		cmd(3'h0, 3'h1, E1_OPS);
		cmd(3'h0, 3'h0, MR_OPS | 14'h0100);
		cmd(3'h2, 3'h0, 14'h0400);
		repeat (2) cmd(3'h1, 3'h0, 14'h0000);
		cmd(3'h0, 3'h0, MR_OPS);
		repeat (200) @(posedge ck);
		cmd(3'h0, 3'h1, E1_OPS | 14'h0380);
		cmd(3'h0, 3'h1, E1_OPS);
		init_done = 1'b1;
	endtask
endmodule // ddr2_ctrl_model

// [sim/ddr2_init_mode_registers_bench.sv]
// Bench for the mode-register device: APB access and link commands.
// Assumes the controller model drives every link pin.
`timescale 1ns/1ns
module ddr2_init_mode_registers_bench;
	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic ck, cke, cs_n, ras_n, cas_n, we_n, init_done;
	logic bank_select_low, bank_select_high, bank_select_reserved;
	logic die_termination_control, termination_on, write_byte_mask_on;
	logic dll_ready, access_valid, access_write, access_auto_precharge;
	logic command_error, got_acc, got_err;
	logic [1:0] access_bank;
	logic [9:0] access_column;
	logic [13:0] addr, access_row, mode_reg, first_extended_register;
	logic [13:0] second_extended_register, third_extended_register;
	logic [27:0] cap;
	int n_fail = 0;
	int checks_done = 0;
	always #20 clk = ~clk;
	ddr2_ctrl_model u_ctrl_model (.ck, .cke, .cs_n, .ras_n, .cas_n, .we_n,
		.bank_select_low, .bank_select_high, .bank_select_reserved, .addr,
		.die_termination_control, .init_done);
	ddr2_mode_device u_ddr2_mode_device (.clk, .rst, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .ck, .cke,
		.cs_n, .ras_n, .cas_n, .we_n, .bank_select_low, .bank_select_high,
		.bank_select_reserved, .addr, .die_termination_control,
		.termination_on, .write_byte_mask_on, .dll_ready, .mode_reg,
		.first_extended_register, .second_extended_register,
		.third_extended_register, .access_valid, .access_write,
		.access_bank, .access_row, .access_column, .access_auto_precharge,
		.command_error);
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; holds the request until pready is seen
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [31:0] exp, input logic err);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (!wr)
			chk(prdata, exp);
		chk({pready, pslverr}, {1'b1, err});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Sends one link command and watches the pulses that follow it
	task automatic send(input logic [2:0] c, input logic [2:0] ba,
		input logic [13:0] a);
		got_acc = 1'b0;
		got_err = 1'b0;
		fork
			u_ctrl_model.cmd(c, ba, a);
			repeat (30) begin
				@(posedge clk);
				#1;
				if (access_valid === 1'b1) begin
					got_acc = 1'b1;
					cap = {access_write, access_auto_precharge, access_bank,
						access_row, access_column};
				end
				if (command_error === 1'b1)
					got_err = 1'b1;
			end
		join
	endtask
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// Reset values, read-only register and a hole in the map
		apb(1'b0, 12'h000, 32'h0, 32'h0000_0001, 1'b0);
		apb(1'b0, 12'h004, 32'h0, 32'h0000_0000, 1'b0);
		apb(1'b1, 12'h008, 32'h0000_FFFF, 32'h0, 1'b0);
		apb(1'b0, 12'h008, 32'h0, 32'h0000_0000, 1'b0);
		apb(1'b0, 12'h01C, 32'h0, 32'h0000_0000, 1'b1);
		chk(write_byte_mask_on, 32'h1);
		u_ctrl_model.init_seq();
		chk(mode_reg, 32'h0453);
		chk(first_extended_register, 32'h000C);
		chk({second_extended_register, third_extended_register}, 32'h0);
		apb(1'b0, 12'h004, 32'h0, 32'h0000_002F, 1'b0);
		// Termination follows the pin once the setting allows it
		u_ctrl_model.die_termination_control <= 1'b1;
		repeat (10) @(posedge clk);
		chk(termination_on, 32'h1);
		u_ctrl_model.die_termination_control <= 1'b0;
		send(3'h3, 3'h2, 14'h2ABC);
		send(3'h4, 3'h2, 14'h0155);
		chk({got_acc, cap}, {3'h6, 2'h2, 14'h2ABC, 10'h155});
		// Mode set with a bank open is refused and changes nothing
		send(3'h0, 3'h0, 14'h0000);
		chk({got_err, mode_reg}, {1'b1, 14'h0453});
		send(3'h5, 3'h2, 14'h04AA);
		chk({got_acc, cap}, {3'h5, 2'h2, 14'h2ABC, 10'h0AA});
		send(3'h5, 3'h2, 14'h0000);
		chk({got_acc, got_err}, 32'h1);
		send(3'h0, 3'h4, 14'h0000);
		chk(got_err, 32'h1);
		// Early read after a fresh DLL reset
		send(3'h0, 3'h0, 14'h0553);
		chk({dll_ready, mode_reg}, {1'b0, 14'h0553});
		send(3'h3, 3'h1, 14'h0001);
		send(3'h5, 3'h1, 14'h0000);
		chk({got_acc, got_err}, 32'h1);
		// A second activate to the open bank and a refresh are refused
		send(3'h3, 3'h1, 14'h0002);
		chk({got_acc, got_err}, 32'h1);
		send(3'h1, 3'h0, 14'h0000);
		chk(got_err, 32'h1);
		send(3'h2, 3'h0, 14'h0400);
		send(3'h0, 3'h1, 14'h0801);
		chk({write_byte_mask_on, dll_ready, first_extended_register},
			{2'h0, 14'h0801});
		apb(1'b0, 12'h018, 32'h0, 32'h0000_0006, 1'b0);
		// Decoder off: a mode set is dropped without a refusal
		apb(1'b1, 12'h000, 32'h0000_0000, 32'h0, 1'b0);
		apb(1'b0, 12'h000, 32'h0, 32'h0000_0000, 1'b0);
		send(3'h0, 3'h1, 14'h0000);
		chk({got_err, first_extended_register}, {1'b0, 14'h0801});
		apb(1'b1, 12'h000, 32'h0000_0003, 32'h0, 1'b0);
		apb(1'b0, 12'h018, 32'h0, 32'h0000_0000, 1'b0);
		end_sim();
	end
	// Power-up takes about 270 us; cut a hang well beyond that
	initial begin
		#2000000;
		n_fail++;
		end_sim();
	end
endmodule // ddr2_init_mode_registers_bench
